//--- lfp_pkg.sv
// Purpose: shared constants and types for the fp / lock-wait execution block
// Assumes: 32-bit apb register words, 64-bit fp registers, 32-bit gprs
// Notes: register offsets are byte addresses
package lfp_pkg;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FP_CSR = 8'h04;
  localparam logic [7:0] ADDR_LOCK_STAT = 8'h08;
  localparam logic [7:0] ADDR_RESUME_PC = 8'h0c;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_INT_CLEAR = 8'h18;

  // ctrl field positions
  localparam int CTRL_WIDE_MODE = 0;
  localparam int CTRL_FPU64 = 1;
  localparam int CTRL_REL6 = 2;
  localparam int CTRL_PAUSE_IMPL = 3;
  localparam int CTRL_COP1_USABLE = 4;
  localparam logic [4:0] CTRL_RESET = 5'h1b;

  // fp csr layout: flags [4:0], enables [9:5], cause [15:10], rounding [17:16]
  localparam int CSR_FLAGS_LSB = 0;
  localparam int CSR_ENABLES_LSB = 5;
  localparam int CSR_CAUSE_LSB = 10;
  localparam int CSR_RM_LSB = 16;
  localparam int CAUSE_UNIMPL = 5;

  // interrupt event bits
  localparam int EV_FP_EXC = 0;
  localparam int EV_RESERVED = 1;
  localparam int EV_COP_UNUSABLE = 2;
  localparam int EV_PAUSE_RELEASE = 3;
  localparam int NUM_EVENTS = 4;

  localparam logic [31:0] PC_STEP = 32'h0000_0004;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SHIFT_LEFT_LOGICAL = 4'h1,
    OP_NOR = 4'h2,
    OP_OR = 4'h3,
    OP_OR_IMMEDIATE = 4'h4,
    OP_PAUSE = 4'h5,
    OP_NEG_MUL_SUBTRACT = 4'h6,
    OP_PAIR_LOWER_LOWER_MERGE = 4'h7
  } lfp_op_t;

  typedef enum logic [1:0] {
    FMT_SINGLE = 2'h0,
    FMT_DOUBLE = 2'h1,
    FMT_PAIRED_SINGLE = 2'h2,
    FMT_ILLEGAL = 2'h3
  } lfp_fmt_t;

  typedef enum logic [1:0] {
    EXC_NONE = 2'h0,
    EXC_COP_UNUSABLE = 2'h1,
    EXC_RESERVED = 2'h2,
    EXC_FP = 2'h3
  } lfp_exc_t;

  typedef struct packed {
    lfp_op_t op;
    lfp_fmt_t fmt;
    logic delay_slot;
    logic [31:0] pc;
    logic [15:0] imm;
    logic [4:0] shamt;
    logic [4:0] dest;
    logic [63:0] src_a;
    logic [63:0] src_b;
    logic [63:0] src_c;
  } lfp_issue_t;

  typedef struct packed {
    logic fp;
    logic defined;
    logic [4:0] dest;
    logic [63:0] data;
  } lfp_wb_t;

  typedef struct packed {
    logic subtract;
    lfp_fmt_t fmt;
    logic [1:0] rm;
    logic [63:0] a;
    logic [63:0] b;
  } lfp_fpu_req_t;

  typedef struct packed {
    logic [63:0] data;
    logic [5:0] cause_hi;
    logic [5:0] cause_lo;
  } lfp_fpu_rsp_t;

endpackage : lfp_pkg

//--- lfp_exec.sv
// Purpose: executes negative multiply-subtract, pair merge, logic ops, no-op and lock-wait
// Assumes: fp arithmetic unit attached on the fpu_req/fpu_rsp port rounds each step itself
// Notes: one instruction in flight; issue_ready stalls the pipeline
// Notes on behaviour
// - multiply, round, subtract addend, round, negate
// - paired halves separately, causes ORed together
// - no exception taken: cause ORed into flags
// - paired result defined only wide 64-bit mode
// - may raise cop-unusable, reserved, fp conditions
// - all-zero word is shift changing nothing
// - not-or writes complement of OR
// - register OR writes bitwise OR
// - immediate zero-extended then ORed
// - lock-wait saves pc+4, waits flag zero
// - wait also ends on external interrupt
// - newest release: lock-wait in slot reserved
// - unimplemented lock-wait runs as no-op
// - store to lock variable clears flag
// - merge: first lower high, second lower low
// - merge raises nothing, csr untouched
// - bad operand field gives undefined result
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module lfp_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire lfp_pkg::lfp_issue_t issue,
  output logic wb_valid,
  output lfp_pkg::lfp_wb_t wb,
  output logic exc_valid,
  output lfp_pkg::lfp_exc_t exc_code,
  output logic fpu_req_valid,
  input wire logic fpu_req_ready,
  output lfp_pkg::lfp_fpu_req_t fpu_req,
  input wire logic fpu_rsp_valid,
  input wire lfp_pkg::lfp_fpu_rsp_t fpu_rsp,
  input wire logic linked_load_set,
  input wire logic lock_store,
  input wire logic ext_event,
  output logic irq
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MUL = 2'b01,
    ST_SUB = 2'b10,
    ST_PAUSED = 2'b11
  } lfp_state_t;

  function automatic logic [63:0] lfp_negate(input logic [63:0] v, input lfp_pkg::lfp_fmt_t f);
    logic [63:0] r;
    r = v;
    if (f == lfp_pkg::FMT_SINGLE || f == lfp_pkg::FMT_PAIRED_SINGLE) begin
      r[31] = ~v[31];
    end
    if (f == lfp_pkg::FMT_DOUBLE || f == lfp_pkg::FMT_PAIRED_SINGLE) begin
      r[63] = ~v[63];
    end
    return r;
  endfunction : lfp_negate

  lfp_state_t state;
  lfp_state_t next_state;
  lfp_pkg::lfp_issue_t held;
  logic [4:0] ctrl;
  logic [4:0] fp_flags;
  logic [4:0] fp_enables;
  logic [5:0] fp_cause;
  logic [1:0] fp_rm;
  logic [5:0] cause_acc;
  logic linked_load_flag;
  logic [31:0] resume_pc;
  logic [3:0] int_status;
  logic [3:0] int_enable;
  logic ext_meta;
  logic ext_sync;

  // apb decode
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & penable & ~pwrite;
  wire hit_ctrl = paddr == lfp_pkg::ADDR_CTRL;
  wire hit_csr = paddr == lfp_pkg::ADDR_FP_CSR;
  wire hit_lock = paddr == lfp_pkg::ADDR_LOCK_STAT;
  wire hit_rpc = paddr == lfp_pkg::ADDR_RESUME_PC;
  wire hit_ist = paddr == lfp_pkg::ADDR_INT_STATUS;
  wire hit_ien = paddr == lfp_pkg::ADDR_INT_ENABLE;
  wire hit_icl = paddr == lfp_pkg::ADDR_INT_CLEAR;
  wire hit_any = hit_ctrl | hit_csr | hit_lock | hit_rpc | hit_ist | hit_ien | hit_icl;
  wire wr_ctrl = apb_wr & hit_ctrl;
  wire wr_csr = apb_wr & hit_csr;
  wire wr_ien = apb_wr & hit_ien;
  wire wr_icl = apb_wr & hit_icl;

  wire wide_mode = ctrl[lfp_pkg::CTRL_WIDE_MODE];
  wire fpu64 = ctrl[lfp_pkg::CTRL_FPU64];
  wire rel6 = ctrl[lfp_pkg::CTRL_REL6];
  wire pause_impl = ctrl[lfp_pkg::CTRL_PAUSE_IMPL];
  wire cop1_ok = ctrl[lfp_pkg::CTRL_COP1_USABLE];

  // issue classification
  wire fire = issue_valid & issue_ready;
  wire is_nms = issue.op == lfp_pkg::OP_NEG_MUL_SUBTRACT;
  wire is_pll = issue.op == lfp_pkg::OP_PAIR_LOWER_LOWER_MERGE;
  wire is_fp = is_nms | is_pll;
  wire is_pause = issue.op == lfp_pkg::OP_PAUSE;
  wire is_int = issue.op inside {lfp_pkg::OP_SHIFT_LEFT_LOGICAL, lfp_pkg::OP_NOR, lfp_pkg::OP_OR,
                                 lfp_pkg::OP_OR_IMMEDIATE};
  wire cop_fault = fire & is_fp & ~cop1_ok;
  wire nms_reserved = is_nms & (rel6 | issue.fmt == lfp_pkg::FMT_ILLEGAL);
  wire pll_reserved = is_pll & (rel6 | issue.fmt != lfp_pkg::FMT_PAIRED_SINGLE);
  wire slot_reserved = is_pause & rel6 & issue.delay_slot;
  wire rsv_fault = fire & ~cop_fault & (nms_reserved | pll_reserved | slot_reserved);
  wire go_nms = fire & is_nms & ~cop_fault & ~rsv_fault;
  wire go_pll = fire & is_pll & ~cop_fault & ~rsv_fault;
  // without the option the encoding falls through as a no-op
  wire go_pause = fire & is_pause & ~slot_reserved & pause_impl & linked_load_flag;
  wire go_int = fire & is_int;

  // integer results on 32-bit gprs
  wire [31:0] gpr_a = issue.src_a[31:0];
  wire [31:0] gpr_b = issue.src_b[31:0];
  wire [31:0] imm_ext = {16'h0000, issue.imm};
  logic [31:0] int_result;
  always_comb begin
    unique case (issue.op)
      lfp_pkg::OP_NOR: int_result = ~(gpr_a | gpr_b);
      lfp_pkg::OP_OR: int_result = gpr_a | gpr_b;
      lfp_pkg::OP_OR_IMMEDIATE: int_result = gpr_a | imm_ext;
      default: int_result = gpr_b << issue.shamt;
    endcase
  end
  // the all-zero word decodes as OP_NONE and writes nothing; a shift to register zero is dropped by the discard below
  wire int_write = go_int & (issue.dest != 5'h00);

  // paired results are only meaningful in wide mode on a 64-bit unit
  wire ps_defined = fpu64 & wide_mode;
  wire [63:0] pll_data = {issue.src_a[31:0], issue.src_b[31:0]};

  // fp completion
  wire sub_done = (state == ST_SUB) & fpu_rsp_valid;
  wire mul_done = (state == ST_MUL) & fpu_rsp_valid;
  wire [5:0] step_cause = fpu_rsp.cause_hi | fpu_rsp.cause_lo;
  wire [5:0] final_cause = cause_acc | step_cause;
  wire fp_trap = final_cause[lfp_pkg::CAUSE_UNIMPL] | (|(final_cause[4:0] & fp_enables));
  wire fp_flag_or = sub_done & ~fp_trap;

  // lock-wait release: flag cleared, or any outside event on a single-threaded core
  wire pause_release = (state == ST_PAUSED) & (~linked_load_flag | ext_sync);

  assign issue_ready = state == ST_IDLE;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (go_nms) begin
          next_state = ST_MUL;
        end else if (go_pause) begin
          next_state = ST_PAUSED;
        end
      end
      ST_MUL: if (mul_done) next_state = ST_SUB;
      ST_SUB: if (sub_done) next_state = ST_IDLE;
      ST_PAUSED: if (pause_release) next_state = ST_IDLE;
    endcase
  end

  // event capture; a set in the clearing cycle survives
  wire [3:0] ev = {pause_release, cop_fault, rsv_fault, sub_done & fp_trap};
  wire [3:0] next_int_status = (int_status & ~(wr_icl ? pwdata[3:0] : 4'h0)) | ev;
  assign irq = |(int_status & int_enable);

  // outside event pin passes two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      ext_meta <= ext_event;
      ext_sync <= ext_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      linked_load_flag <= 1'b0;
      resume_pc <= 32'h0000_0000;
      int_status <= 4'h0;
      int_enable <= 4'h0;
      ctrl <= lfp_pkg::CTRL_RESET;
    end else begin
      state <= next_state;
      // a linked load wins over a store in the same cycle
      linked_load_flag <= linked_load_set | (linked_load_flag & ~lock_store);
      if (go_pause) resume_pc <= issue.pc + lfp_pkg::PC_STEP;
      int_status <= next_int_status;
      if (wr_ien) int_enable <= pwdata[3:0];
      if (wr_ctrl) ctrl <= pwdata[4:0];
    end
  end

  // fp control/status; cause takes the hardware update over a same-cycle software write, flags take the two ORed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fp_flags <= 5'h00;
      fp_enables <= 5'h00;
      fp_cause <= 6'h00;
      fp_rm <= 2'h0;
    end else begin
      if (wr_csr) begin
        fp_enables <= pwdata[lfp_pkg::CSR_ENABLES_LSB +: 5];
        fp_rm <= pwdata[lfp_pkg::CSR_RM_LSB +: 2];
      end
      fp_flags <= (wr_csr ? pwdata[lfp_pkg::CSR_FLAGS_LSB +: 5] : fp_flags)
                  | (fp_flag_or ? final_cause[4:0] : 5'h00);
      // the merge path never touches cause or flags
      if (sub_done) begin
        fp_cause <= final_cause;
      end else if (wr_csr) begin
        fp_cause <= pwdata[lfp_pkg::CSR_CAUSE_LSB +: 6];
      end
    end
  end

  // fp sequencing: product step then subtract step, each rounded by the unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= '0;
      cause_acc <= 6'h00;
      fpu_req_valid <= 1'b0;
      fpu_req <= '0;
    end else begin
      if (go_nms) begin
        held <= issue;
        cause_acc <= 6'h00;
        fpu_req_valid <= 1'b1;
        // operand fields are trusted; an illegal register gives an undefined result
        fpu_req <= '{subtract: 1'b0, fmt: issue.fmt, rm: fp_rm, a: issue.src_a, b: issue.src_b};
      end else if (mul_done) begin
        cause_acc <= step_cause;
        fpu_req_valid <= 1'b1;
        fpu_req <= '{subtract: 1'b1, fmt: held.fmt, rm: fp_rm, a: fpu_rsp.data, b: held.src_c};
      end else if (fpu_req_ready) begin
        fpu_req_valid <= 1'b0;
      end
    end
  end

  // writeback and exception outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_valid <= 1'b0;
      wb <= '0;
      exc_valid <= 1'b0;
      exc_code <= lfp_pkg::EXC_NONE;
    end else begin
      wb_valid <= int_write | go_pll | (sub_done & ~fp_trap);
      exc_valid <= cop_fault | rsv_fault | (sub_done & fp_trap);
      if (cop_fault) begin
        exc_code <= lfp_pkg::EXC_COP_UNUSABLE;
      end else if (rsv_fault) begin
        exc_code <= lfp_pkg::EXC_RESERVED;
      end else if (sub_done & fp_trap) begin
        exc_code <= lfp_pkg::EXC_FP;
      end
      if (int_write) begin
        wb <= '{fp: 1'b0, defined: 1'b1, dest: issue.dest, data: {32'h0000_0000, int_result}};
      end else if (go_pll) begin
        wb <= '{fp: 1'b1, defined: ps_defined, dest: issue.dest, data: pll_data};
      end else if (sub_done) begin
        wb <= '{fp: 1'b1, defined: held.fmt != lfp_pkg::FMT_PAIRED_SINGLE || ps_defined, dest: held.dest,
                data: lfp_negate(fpu_rsp.data, held.fmt)};
      end
    end
  end

  // apb read mux; slave answers with no wait states
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) rd_mux = {27'h0, ctrl};
    if (hit_csr) rd_mux = {14'h0, fp_rm, fp_cause, fp_enables, fp_flags};
    if (hit_lock) rd_mux = {30'h0, state == ST_PAUSED, linked_load_flag};
    if (hit_rpc) rd_mux = resume_pc;
    if (hit_ist) rd_mux = {28'h0, int_status};
    if (hit_ien) rd_mux = {28'h0, int_enable};
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  // checks
  sequence nms_issue_s;
    go_nms;
  endsequence
  sequence sub_finish_s;
    sub_done ##1 wb_valid;
  endsequence

  nms_sequence_a: assert property (@(posedge pclk) disable iff (!presetn)
    nms_issue_s |=> state == ST_MUL && !fpu_req.subtract && fpu_req_valid)
    else $error("multiply step not started");
  nms_negate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sub_done && !fp_trap && held.fmt == lfp_pkg::FMT_SINGLE) |=> wb.data[31] == !$past(fpu_rsp.data[31]))
    else $error("result sign not inverted");
  cause_or_a: assert property (@(posedge pclk) disable iff (!presetn)
    mul_done |=> cause_acc == ($past(fpu_rsp.cause_hi) | $past(fpu_rsp.cause_lo)))
    else $error("lane causes not combined");
  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fp_flag_or && !wr_csr) |=> (fp_flags & $past(final_cause[4:0])) == $past(final_cause[4:0]))
    else $error("cause not merged into flags");
  trap_exc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sub_done && fp_trap) |=> exc_valid && exc_code == lfp_pkg::EXC_FP && !wb_valid)
    else $error("fp trap not signalled");
  cop_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    cop_fault |=> exc_valid && exc_code == lfp_pkg::EXC_COP_UNUSABLE && !wb_valid)
    else $error("cop-unusable not signalled");
  ps_defined_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go_pll && !(fpu64 && wide_mode)) |=> wb_valid && !wb.defined)
    else $error("paired result marked defined");
  nor_result_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && issue.op == lfp_pkg::OP_NOR && issue.dest != 5'h00) |=> wb.data[31:0] == ~($past(gpr_a) | $past(gpr_b)))
    else $error("not-or result wrong");
  or_result_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && issue.op == lfp_pkg::OP_OR && issue.dest != 5'h00) |=> wb.data[31:0] == ($past(gpr_a) | $past(gpr_b)))
    else $error("or result wrong");
  or_imm_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && issue.op == lfp_pkg::OP_OR_IMMEDIATE && issue.dest != 5'h00)
    |=> wb.data[31:0] == ($past(gpr_a) | {16'h0000, $past(issue.imm)}))
    else $error("or-immediate result wrong");
  zero_dest_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go_int && issue.dest == 5'h00 && !go_pll) |=> !wb_valid)
    else $error("register zero written");
  pause_pc_a: assert property (@(posedge pclk) disable iff (!presetn)
    go_pause |=> resume_pc == $past(issue.pc) + lfp_pkg::PC_STEP && state == ST_PAUSED)
    else $error("resume address wrong");
  pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_PAUSED && linked_load_flag && !ext_sync) |=> state == ST_PAUSED)
    else $error("lock-wait ended early");
  ext_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_PAUSED && ext_sync) |=> state == ST_IDLE && int_status[lfp_pkg::EV_PAUSE_RELEASE])
    else $error("outside event did not release");
  pause_nop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && is_pause && !pause_impl && !slot_reserved) |=> state == ST_IDLE && !wb_valid && !exc_valid)
    else $error("unimplemented lock-wait not a no-op");
  slot_rsv_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && slot_reserved && cop1_ok) |=> exc_valid && exc_code == lfp_pkg::EXC_RESERVED)
    else $error("slot lock-wait not reserved");
  pll_merge_a: assert property (@(posedge pclk) disable iff (!presetn)
    go_pll |=> wb_valid && wb.data == {$past(issue.src_a[31:0]), $past(issue.src_b[31:0])})
    else $error("merge halves misplaced");
  merge_csr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go_pll && !wr_csr) |=> $stable(fp_cause) && $stable(fp_flags))
    else $error("merge changed csr");
  store_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lock_store && !linked_load_set) |=> !linked_load_flag)
    else $error("flag not cleared by store");
  sub_complete_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sub_done && !fp_trap) |-> ##0 sub_finish_s)
    else $error("no write after subtract");

endmodule : lfp_exec

//--- lfp_exec_test.sv
// Purpose: self-checking bench for the fp / lock-wait execution block
// Assumes: bench plays pipeline, apb master and fp arithmetic unit
// Notes: expected results queue in issue order; a monitor pops one per pulse
`timescale 1ns/10ps
module lfp_exec_test;
  typedef logic [73:0] lfp_note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, csr_keep;
  logic issue_valid, issue_ready, wb_valid, exc_valid;
  logic fpu_req_valid, fpu_req_ready, fpu_rsp_valid;
  logic linked_load_set, lock_store, ext_event, irq;
  lfp_pkg::lfp_issue_t issue, ins;
  lfp_pkg::lfp_wb_t wb;
  lfp_pkg::lfp_exc_t exc_code;
  lfp_pkg::lfp_fpu_req_t fpu_req;
  lfp_pkg::lfp_fpu_rsp_t fpu_rsp;
  lfp_note_t exp_q[$];
  lfp_note_t seen;
  int error_cnt, checks;
  logic [63:0] a, b, c, m, r;

  lfp_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .issue_valid(issue_valid), .issue_ready(issue_ready), .issue(issue), .wb_valid(wb_valid), .wb(wb),
    .exc_valid(exc_valid), .exc_code(exc_code), .fpu_req_valid(fpu_req_valid),
    .fpu_req_ready(fpu_req_ready), .fpu_req(fpu_req), .fpu_rsp_valid(fpu_rsp_valid), .fpu_rsp(fpu_rsp),
    .linked_load_set(linked_load_set), .lock_store(lock_store), .ext_event(ext_event), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic lfp_note_t wbn(input logic fp, input logic def, input logic [4:0] d, input logic [63:0] v);
    return {3'h0, fp, def, d, v};
  endfunction : wbn

  function automatic lfp_note_t exn(input lfp_pkg::lfp_exc_t code);
    return {1'b1, code, 71'h0};
  endfunction : exn

  task automatic check(input lfp_note_t got, input lfp_note_t want);
    checks++;
    if (got !== want) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, got, want);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic give_up();
    error_cnt++;
    $display("ERROR %0t wait limit reached", $time);
    conclude();
  endtask : give_up

  // apb master: hold the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) give_up();
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_ready();
    int n;
    n = 0;
    while (issue_ready !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 50) give_up();
    end
  endtask : wait_ready

  task automatic issue_op(input lfp_pkg::lfp_issue_t i);
    @(posedge pclk);
    issue_valid <= 1'b1;
    issue <= i;
    @(posedge pclk);
    wait_ready();
    issue_valid <= 1'b0;
  endtask : issue_op

  // fp unit stand-in: stalls one cycle before accepting, answers a cycle later
  task automatic fpu_serve(input logic sub, input logic [63:0] ea, input logic [63:0] eb,
                           input logic [63:0] v, input logic [5:0] ch, input logic [5:0] cl);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) give_up();
    end while (fpu_req_valid !== 1'b1);
    fpu_req_ready <= 1'b1;
    @(posedge pclk);
    check(74'(fpu_req.a), 74'(ea));
    check(74'(fpu_req.b), 74'(eb));
    check(74'({fpu_req.subtract, fpu_req.rm, fpu_req.fmt}), 74'({sub, 2'h2, ins.fmt}));
    fpu_req_ready <= 1'b0;
    fpu_rsp_valid <= 1'b1;
    fpu_rsp <= '{data: v, cause_hi: ch, cause_lo: cl};
    @(posedge pclk);
    fpu_rsp_valid <= 1'b0;
  endtask : fpu_serve

  task automatic flag_pulse(input logic set);
    @(posedge pclk);
    linked_load_set <= set;
    lock_store <= ~set;
    @(posedge pclk);
    linked_load_set <= 1'b0;
    lock_store <= 1'b0;
  endtask : flag_pulse

  task automatic pause_op(input logic slot);
    ins = '0;
    ins.op = lfp_pkg::OP_PAUSE;
    ins.delay_slot = slot;
    ins.pc = seed;
    issue_op(ins);
    repeat (3) @(posedge pclk);
  endtask : pause_op

  always @(posedge pclk) begin
    if (presetn === 1'b1 && (wb_valid === 1'b1 || exc_valid === 1'b1)) begin
      seen = exc_valid ? {1'b1, exc_code, 71'h0} :
        {3'h0, wb.fp, wb.defined, wb.dest, wb.fp ? wb.data : {32'h0, wb.data[31:0]}};
      if (exp_q.size() == 0) check(seen, ~seen);
      else check(seen, exp_q.pop_front());
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {issue_valid, fpu_req_ready, fpu_rsp_valid, linked_load_set, lock_store, ext_event} = '0;
    issue = '0;
    fpu_rsp = '0;
    error_cnt = 0;
    checks = 0;
    seed = 32'h0001_496f;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h1c, 32'h0);
    check(74'({err, rd}), 74'({1'b1, 32'h0}));
    for (int k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      a = {32'h0, (k % 3 == 2) ? (seed & 32'h0000ffff) : seed};
      seed = lfsr(seed);
      b = {32'h0, seed | 32'h0000_8000};
      ins = '0;
      ins.op = (k % 3 == 0) ? lfp_pkg::OP_NOR : (k % 3 == 1) ? lfp_pkg::OP_OR : lfp_pkg::OP_OR_IMMEDIATE;
      ins.dest = 5'(k + 1);
      ins.src_a = a;
      ins.src_b = b;
      ins.imm = b[15:0];
      r = (k % 3 == 0) ? ~(a | b) : (k % 3 == 1) ? (a | b) : (a | {48'h0, b[15:0]});
      exp_q.push_back(wbn(1'b0, 1'b1, ins.dest, {32'h0, r[31:0]}));
      issue_op(ins);
    end
    issue_op('0);
    ins = '0;
    ins.op = lfp_pkg::OP_SHIFT_LEFT_LOGICAL;
    issue_op(ins);
    apb(1'b1, lfp_pkg::ADDR_FP_CSR, 32'h0002_0000);
    a = {lfsr(seed), seed};
    b = {a[31:0], a[63:32]};
    c = ~a;
    m = a ^ 64'h0123_4567_89ab_cdef;
    r = b ^ 64'h1111_2222_3333_4444;
    ins = '0;
    ins.op = lfp_pkg::OP_NEG_MUL_SUBTRACT;
    ins.fmt = lfp_pkg::FMT_PAIRED_SINGLE;
    ins.dest = 5'h09;
    ins.src_a = a;
    ins.src_b = b;
    ins.src_c = c;
    exp_q.push_back(wbn(1'b1, 1'b1, 5'h09, r ^ 64'h8000_0000_8000_0000));
    issue_op(ins);
    fpu_serve(1'b0, a, b, m, 6'h01, 6'h00);
    fpu_serve(1'b1, m, c, r, 6'h00, 6'h04);
    repeat (3) @(posedge pclk);
    apb(1'b0, lfp_pkg::ADDR_FP_CSR, 32'h0);
    csr_keep = rd;
    check(74'(rd & 32'h1f), 74'(32'h05));
    ins.op = lfp_pkg::OP_PAIR_LOWER_LOWER_MERGE;
    ins.dest = 5'h0a;
    exp_q.push_back(wbn(1'b1, 1'b1, 5'h0a, {a[31:0], b[31:0]}));
    issue_op(ins);
    apb(1'b1, lfp_pkg::ADDR_CTRL, 32'h1a);
    exp_q.push_back(wbn(1'b1, 1'b0, 5'h0a, {a[31:0], b[31:0]}));
    issue_op(ins);
    apb(1'b0, lfp_pkg::ADDR_FP_CSR, 32'h0);
    check(74'(rd), 74'(csr_keep));
    apb(1'b1, lfp_pkg::ADDR_CTRL, 32'h0b);
    ins.op = lfp_pkg::OP_NEG_MUL_SUBTRACT;
    exp_q.push_back(exn(lfp_pkg::EXC_COP_UNUSABLE));
    issue_op(ins);
    apb(1'b1, lfp_pkg::ADDR_CTRL, 32'h1b);
    // double format: first pass clean, second pass traps on an unimplemented cause
    ins.fmt = lfp_pkg::FMT_DOUBLE;
    for (int t = 0; t < 2; t++) begin
      exp_q.push_back(t ? exn(lfp_pkg::EXC_FP) : wbn(1'b1, 1'b1, 5'h0a, r ^ 64'h8000_0000_0000_0000));
      issue_op(ins);
      fpu_serve(1'b0, a, b, m, 6'(t << 5), 6'h00);
      fpu_serve(1'b1, m, c, r, 6'h00, 6'h00);
    end
    flag_pulse(1'b1);
    pause_op(1'b0);
    check(74'(issue_ready), 74'(1'b0));
    apb(1'b0, lfp_pkg::ADDR_RESUME_PC, 32'h0);
    check(74'(rd), 74'(seed + 32'h4));
    apb(1'b0, lfp_pkg::ADDR_LOCK_STAT, 32'h0);
    check(74'(rd[1:0]), 74'(2'h3));
    flag_pulse(1'b0);
    wait_ready();
    apb(1'b0, lfp_pkg::ADDR_LOCK_STAT, 32'h0);
    check(74'(rd[1:0]), 74'(2'h0));
    apb(1'b0, lfp_pkg::ADDR_INT_STATUS, 32'h0);
    check(74'({rd[3], irq}), 74'(2'b10));
    apb(1'b1, lfp_pkg::ADDR_INT_ENABLE, 32'h8);
    @(posedge pclk);
    check(74'(irq), 74'(1'b1));
    apb(1'b1, lfp_pkg::ADDR_INT_CLEAR, 32'h8);
    @(posedge pclk);
    check(74'(irq), 74'(1'b0));
    flag_pulse(1'b1);
    pause_op(1'b0);
    ext_event <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_event <= 1'b0;
    wait_ready();
    flag_pulse(1'b0);
    pause_op(1'b0);
    check(74'(issue_ready), 74'(1'b1));
    apb(1'b1, lfp_pkg::ADDR_CTRL, 32'h13);
    flag_pulse(1'b1);
    pause_op(1'b0);
    check(74'(issue_ready), 74'(1'b1));
    flag_pulse(1'b0);
    apb(1'b1, lfp_pkg::ADDR_CTRL, 32'h1f);
    exp_q.push_back(exn(lfp_pkg::EXC_RESERVED));
    pause_op(1'b1);
    ins.op = lfp_pkg::OP_NEG_MUL_SUBTRACT;
    exp_q.push_back(exn(lfp_pkg::EXC_RESERVED));
    issue_op(ins);
    repeat (5) @(posedge pclk);
    check(74'(exp_q.size()), 74'(0));
    conclude();
  end
endmodule : lfp_exec_test
